// >>> common/lds_pkg.sv
/*
 * lds_pkg: shared types and constants of the loop-diagnostics exchange sequencer.
 * Assumes one symbol strobe per line-symbol period from the surrounding modem datapath.
 */
package lds_pkg;

	localparam int LDS_CNT_W = 9;
	localparam int LDS_SEQ_W = 8;
	localparam int LDS_OCT_W = 9;

	// symbol counts per state
	localparam int LDS_ACK_SYMS = 64;
	localparam int LDS_NACK_SYMS = 64;
	localparam int LDS_TREF2_SYMS = 256;
	localparam int LDS_SEGUE_SYMS = 64;
	localparam int LDS_TREF3_SYMS = 256;
	localparam int LDS_SYMS_PER_BIT = 8;
	localparam int LDS_DECIDE_MAX_SYMS = 128;
	localparam logic [LDS_CNT_W-1:0] LDS_ACK_LAST = LDS_CNT_W'(LDS_ACK_SYMS - 1);
	localparam logic [LDS_CNT_W-1:0] LDS_NACK_LAST = LDS_CNT_W'(LDS_NACK_SYMS - 1);
	localparam logic [LDS_CNT_W-1:0] LDS_TREF2_LAST = LDS_CNT_W'(LDS_TREF2_SYMS - 1);
	localparam logic [LDS_CNT_W-1:0] LDS_SEGUE_LAST = LDS_CNT_W'(LDS_SEGUE_SYMS - 1);
	localparam logic [LDS_CNT_W-1:0] LDS_TREF3_LAST = LDS_CNT_W'(LDS_TREF3_SYMS - 1);
	localparam logic [2:0] LDS_BIT_LAST = 3'(LDS_SYMS_PER_BIT - 1);

	// acknowledgement octet and remote message identities
	localparam logic [7:0] LDS_ACK_OCTET = 8'h55;
	localparam logic [LDS_SEQ_W-1:0] LDS_SEQ_NONE = 8'h00;
	localparam logic [LDS_SEQ_W-1:0] LDS_RSEQ1 = 8'h11;
	localparam logic [LDS_SEQ_W-1:0] LDS_RSEQ2 = 8'h22;
	localparam logic [LDS_SEQ_W-1:0] LDS_RSEQ3 = 8'h33;
	localparam logic [LDS_OCT_W-1:0] LDS_RMSG1_OCTETS = 9'h010;
	localparam logic [LDS_OCT_W-1:0] LDS_RMSG23_OCTETS = 9'h102;

	typedef enum logic [1:0] {
		LDS_SYM_QUIET = 2'h0,
		LDS_SYM_REF = 2'h1,
		LDS_SYM_SEGUE = 2'h2,
		LDS_SYM_REVERB = 2'h3
	} lds_sym_type;

	typedef enum logic [8:0] {
		LDS_ST_IDLE = 9'h001,
		LDS_ST_TREF1 = 9'h002,
		LDS_ST_ACK = 9'h004,
		LDS_ST_NACK = 9'h008,
		LDS_ST_TREF2 = 9'h010,
		LDS_ST_SEGUE = 9'h020,
		LDS_ST_MSG = 9'h040,
		LDS_ST_TREF3 = 9'h080,
		LDS_ST_DONE = 9'h100
	} lds_state_type;

	// end of one received remote message, as reported by the demodulator
	typedef struct packed {
		logic msg_end;
		logic crc_ok;
		logic [LDS_SEQ_W-1:0] seq;
		logic [LDS_OCT_W-1:0] octets;
	} lds_rx_type;

	// accepted remote message handed to the diagnostics store
	typedef struct packed {
		logic [LDS_SEQ_W-1:0] seq;
		logic [LDS_OCT_W-1:0] octets;
	} lds_rec_type;

	localparam int LDS_REC_W = $bits(lds_rec_type);

endpackage

// >>> rtl/lds_sym_cnt.sv
/*
 * lds_sym_cnt: symbol-period counter, cleared on request, advanced once per strobe.
 * Assumes clr and stb are synchronous to sys_clk_i and gated by the caller's enable.
 */
`timescale 1ns/1ps
module lds_sym_cnt #(
	parameter int WIDTH = 9
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// control
	input wire logic clr_i,
	input wire logic stb_i,
	// count
	output logic [WIDTH-1:0] cnt_o
);

	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] cnt_nxt;

	if (WIDTH < 1) begin : g_width_chk
		$error("lds_sym_cnt: WIDTH must be at least 1");
	end

	always_comb begin
		cnt_nxt = cnt_r;
		if (clr_i) begin
			cnt_nxt = '0;
		end else if (stb_i) begin
			cnt_nxt = cnt_r + WIDTH'(1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cnt_r <= '0;
		end else if (clk_en_i) begin
			cnt_r <= cnt_nxt;
		end
	end

	assign cnt_o = cnt_r;

endmodule

// >>> rtl/lds_buf2.sv
/*
 * lds_buf2: two-entry buffer with valid/ready on both sides.
 * Assumes the drain side may hold ready low indefinitely; in_ready_o falls only when full.
 */
`timescale 1ns/1ps
module lds_buf2 #(
	parameter int WIDTH = 17
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	logic [WIDTH-1:0] mem_r [2];
	logic [WIDTH-1:0] mem_nxt [2];
	logic rd_r, rd_nxt, wr_r, wr_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;

	if (WIDTH < 1) begin : g_width_chk
		$error("lds_buf2: WIDTH must be at least 1");
	end

	assign in_ready_o = (cnt_r != 2'h2);
	assign out_valid_o = (cnt_r != 2'h0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		mem_nxt = mem_r;
		rd_nxt = rd_r;
		wr_nxt = wr_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wr_r] = in_data_i;
			wr_nxt = ~wr_r;
		end
		if (pop) begin
			rd_nxt = ~rd_r;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 2'h1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 2'h1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			cnt_r <= 2'h0;
		end else if (clk_en_i) begin
			mem_r <= mem_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign out_data_o = mem_r[rd_r];

endmodule

// >>> rtl/lds_seq.sv
/*
 * lds_seq: central-office exchange-phase sequencer for loop diagnostics.
 * Assumes sym_stb_i pulses once per symbol period, the receiver reports each
 * remote message end with CRC verdict, sequence octet and octet count, and the
 * message source presents the next bit (CRC included) on tx_bit_i before each take.
 */
`timescale 1ns/1ps
module lds_seq
	import lds_pkg::*;
#(
	parameter int RESEND_W = 4
) (
	// clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// sequencing control
	input wire logic sym_stb_i,
	input wire logic exch_start_i,
	input wire logic [RESEND_W-1:0] resend_limit_i,
	// receiver status
	input wire lds_rx_type rx_i,
	input wire logic rx_quiet_i,
	input wire logic rx_ack_ok_i,
	// local message source
	input wire logic tx_bit_i,
	input wire logic tx_last_i,
	input wire logic tx_more_i,
	output logic tx_take_o,
	output logic tx_next_o,
	output logic tx_rewind_o,
	// line symbol out
	output lds_sym_type tx_sym_o,
	// accepted remote messages
	output logic rec_valid_o,
	input wire logic rec_ready_i,
	output lds_rec_type rec_o,
	// link status
	output logic init_reset_o,
	output logic limit_evt_o,
	output logic link_l3_o
);

	if (RESEND_W < 1 || RESEND_W > 16) begin : g_resend_chk
		$error("lds_seq: RESEND_W out of range");
	end

	lds_state_type state_r, state_nxt;
	lds_sym_type sym_r, sym_nxt;
	logic [LDS_CNT_W-1:0] cnt;
	logic cnt_clr;
	logic [LDS_SEQ_W-1:0] last_seq_r, last_seq_nxt;
	logic [RESEND_W-1:0] resend_r, resend_nxt;
	logic cur_bit_r, cur_bit_nxt, cur_last_r, cur_last_nxt;
	logic ack_seen_r, ack_seen_nxt;
	logic next_r, next_nxt, rewind_r, rewind_nxt;
	logic init_r, init_nxt, limit_r, limit_nxt, l3_r, l3_nxt;
	logic len_ok, is_dup, rec_push, rec_ready, take;
	lds_rec_type rec_in;

	// state timing
	lds_sym_cnt #(.WIDTH(LDS_CNT_W)) u_cnt (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.clr_i(cnt_clr),
		.stb_i(sym_stb_i),
		.cnt_o(cnt)
	);

	// a full buffer forces a negative acknowledge of a non-duplicate message, so the remote resends later
	lds_buf2 #(.WIDTH(LDS_REC_W)) u_buf (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.in_valid_i(rec_push),
		.in_ready_o(rec_ready),
		.in_data_i(rec_in),
		.out_valid_o(rec_valid_o),
		.out_ready_i(rec_ready_i),
		.out_data_o(rec_o)
	);

	// message length check for the layouts this side knows; others pass
	always_comb begin
		if (rx_i.seq == LDS_RSEQ1) begin
			len_ok = (rx_i.octets == LDS_RMSG1_OCTETS);
		end else if (rx_i.seq == LDS_RSEQ2 || rx_i.seq == LDS_RSEQ3) begin
			len_ok = (rx_i.octets == LDS_RMSG23_OCTETS);
		end else begin
			len_ok = 1'b1;
		end
	end

	assign is_dup = (rx_i.seq == last_seq_r);
	assign rec_in = '{seq: rx_i.seq, octets: rx_i.octets};
	assign rec_push = clk_en_i && state_r == LDS_ST_TREF1 && rx_i.msg_end && rx_i.crc_ok
		&& len_ok && !is_dup;
	assign take = (state_r == LDS_ST_SEGUE && sym_stb_i && cnt == LDS_SEGUE_LAST)
		|| (state_r == LDS_ST_MSG && sym_stb_i && cnt[2:0] == LDS_BIT_LAST && !cur_last_r);
	assign tx_take_o = clk_en_i && take;

	always_comb begin
		state_nxt = state_r;
		cnt_clr = 1'b0;
		last_seq_nxt = last_seq_r;
		resend_nxt = resend_r;
		cur_bit_nxt = cur_bit_r;
		cur_last_nxt = cur_last_r;
		ack_seen_nxt = ack_seen_r;
		next_nxt = 1'b0;
		rewind_nxt = 1'b0;
		init_nxt = 1'b0;
		limit_nxt = limit_r;
		l3_nxt = l3_r;
		if (take) begin
			cur_bit_nxt = tx_bit_i;
			cur_last_nxt = tx_last_i;
		end
		case (state_r)
			LDS_ST_IDLE: begin
				if (exch_start_i) begin
					state_nxt = LDS_ST_TREF1;
					cnt_clr = 1'b1;
					last_seq_nxt = LDS_SEQ_NONE;
					resend_nxt = '0;
					limit_nxt = 1'b0;
				end
			end
			LDS_ST_TREF1: begin
				if (rx_i.msg_end) begin
					cnt_clr = 1'b1;
					if (rx_i.crc_ok && len_ok && (is_dup || rec_ready)) begin
						state_nxt = LDS_ST_ACK;
						last_seq_nxt = rx_i.seq;
					end else begin
						state_nxt = LDS_ST_NACK;
					end
				end
			end
			LDS_ST_ACK: begin
				if (sym_stb_i && cnt == LDS_ACK_LAST) begin
					state_nxt = LDS_ST_TREF2;
					cnt_clr = 1'b1;
				end
			end
			LDS_ST_NACK: begin
				if (sym_stb_i && cnt == LDS_NACK_LAST) begin
					state_nxt = LDS_ST_TREF2;
					cnt_clr = 1'b1;
				end
			end
			LDS_ST_TREF2: begin
				if (sym_stb_i && cnt == LDS_TREF2_LAST) begin
					cnt_clr = 1'b1;
					// remote decides during this state which way it goes
					state_nxt = rx_quiet_i ? LDS_ST_SEGUE : LDS_ST_TREF1;
				end
			end
			LDS_ST_SEGUE: begin
				if (sym_stb_i && cnt == LDS_SEGUE_LAST) begin
					state_nxt = LDS_ST_MSG;
					cnt_clr = 1'b1;
				end
			end
			LDS_ST_MSG: begin
				if (sym_stb_i && cnt[2:0] == LDS_BIT_LAST) begin
					cnt_clr = 1'b1;
					if (cur_last_r) begin
						state_nxt = LDS_ST_TREF3;
						ack_seen_nxt = 1'b0;
					end
				end
			end
			LDS_ST_TREF3: begin
				if (rx_ack_ok_i) begin
					ack_seen_nxt = 1'b1;
				end
				if (sym_stb_i && cnt == LDS_TREF3_LAST) begin
					cnt_clr = 1'b1;
					if ((ack_seen_r || rx_ack_ok_i) && !tx_more_i) begin
						state_nxt = LDS_ST_DONE;
						l3_nxt = 1'b1;
					end else if (ack_seen_r || rx_ack_ok_i) begin
						state_nxt = LDS_ST_SEGUE;
						next_nxt = 1'b1;
						resend_nxt = '0;
					end else if (resend_r + RESEND_W'(1) >= resend_limit_i) begin
						state_nxt = LDS_ST_IDLE;
						init_nxt = 1'b1;
						limit_nxt = 1'b1;
					end else begin
						state_nxt = LDS_ST_SEGUE;
						rewind_nxt = 1'b1;
						resend_nxt = resend_r + RESEND_W'(1);
					end
				end
			end
			LDS_ST_DONE: begin
				state_nxt = LDS_ST_DONE;
			end
			default: begin
				state_nxt = LDS_ST_IDLE;
				cnt_clr = 1'b1;
			end
		endcase
	end

	// line symbol follows the state one cycle later
	always_comb begin
		case (state_r)
			LDS_ST_TREF1, LDS_ST_NACK, LDS_ST_TREF2, LDS_ST_TREF3: begin
				sym_nxt = LDS_SYM_REF;
			end
			LDS_ST_ACK: begin
				// acknowledge octet bits leave least significant first
				sym_nxt = LDS_ACK_OCTET[cnt[5:3]] ? LDS_SYM_SEGUE : LDS_SYM_REVERB;
			end
			LDS_ST_SEGUE: begin
				sym_nxt = LDS_SYM_SEGUE;
			end
			LDS_ST_MSG: begin
				sym_nxt = cur_bit_r ? LDS_SYM_SEGUE : LDS_SYM_REVERB;
			end
			default: begin
				sym_nxt = LDS_SYM_QUIET;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_r <= LDS_ST_IDLE;
			sym_r <= LDS_SYM_QUIET;
			last_seq_r <= LDS_SEQ_NONE;
			resend_r <= '0;
			cur_bit_r <= 1'b0;
			cur_last_r <= 1'b0;
			ack_seen_r <= 1'b0;
			next_r <= 1'b0;
			rewind_r <= 1'b0;
			init_r <= 1'b0;
			limit_r <= 1'b0;
			l3_r <= 1'b0;
		end else if (clk_en_i) begin
			state_r <= state_nxt;
			sym_r <= sym_nxt;
			last_seq_r <= last_seq_nxt;
			resend_r <= resend_nxt;
			cur_bit_r <= cur_bit_nxt;
			cur_last_r <= cur_last_nxt;
			ack_seen_r <= ack_seen_nxt;
			next_r <= next_nxt;
			rewind_r <= rewind_nxt;
			init_r <= init_nxt;
			limit_r <= limit_nxt;
			l3_r <= l3_nxt;
		end
	end

	assign tx_sym_o = sym_r;
	assign tx_next_o = next_r;
	assign tx_rewind_o = rewind_r;
	assign init_reset_o = init_r;
	assign limit_evt_o = limit_r;
	assign link_l3_o = l3_r;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	a_start_tref1: assert property (clk_en_i && state_r == LDS_ST_IDLE && exch_start_i
		|=> state_r == LDS_ST_TREF1 ##1 (tx_sym_o == LDS_SYM_REF || state_r != LDS_ST_TREF1))
		else $error("exchange start did not enter first reference");
	a_decide_fast: assert property (clk_en_i && state_r == LDS_ST_TREF1 && rx_i.msg_end
		|=> state_r inside {LDS_ST_ACK, LDS_ST_NACK})
		else $error("no acknowledge decision after remote message");
	a_crc_bad_nack: assert property (clk_en_i && state_r == LDS_ST_TREF1 && rx_i.msg_end
		&& !rx_i.crc_ok |=> state_r == LDS_ST_NACK)
		else $error("bad CRC did not select negative acknowledge");
	a_ack_pattern: assert property (clk_en_i && state_r == LDS_ST_ACK
		|=> tx_sym_o == (LDS_ACK_OCTET[$past(cnt[5:3])] ? LDS_SYM_SEGUE : LDS_SYM_REVERB))
		else $error("acknowledge symbol does not follow octet");
	a_nack_ref: assert property (clk_en_i && state_r == LDS_ST_NACK |=> tx_sym_o == LDS_SYM_REF)
		else $error("negative acknowledge sent non-reference symbol");
	a_ack_to_tref2: assert property (clk_en_i && sym_stb_i && cnt == LDS_ACK_LAST
		&& state_r inside {LDS_ST_ACK, LDS_ST_NACK} |=> state_r == LDS_ST_TREF2 && cnt == '0)
		else $error("acknowledge state did not last 64 symbols");
	a_tref2_exit: assert property (clk_en_i && sym_stb_i && state_r == LDS_ST_TREF2
		&& cnt == LDS_TREF2_LAST |=> state_r == ($past(rx_quiet_i) ? LDS_ST_SEGUE : LDS_ST_TREF1))
		else $error("wrong exit from second reference");
	a_dup_dropped: assert property (clk_en_i && state_r == LDS_ST_TREF1 && rx_i.msg_end
		&& rx_i.crc_ok && len_ok && rx_i.seq == last_seq_r && !rec_ready_i
		|=> state_r == LDS_ST_ACK && u_buf.cnt_r == $past(u_buf.cnt_r))
		else $error("duplicate remote message forwarded");
	a_segue_to_msg: assert property (clk_en_i && sym_stb_i && state_r == LDS_ST_SEGUE
		&& cnt == LDS_SEGUE_LAST |-> tx_take_o ##1 state_r == LDS_ST_MSG)
		else $error("segue not followed by message");
	a_resend_rewind: assert property (clk_en_i && rewind_nxt |=> tx_rewind_o
		&& state_r == LDS_ST_SEGUE && resend_r != '0)
		else $error("resend did not rewind the message");
	a_limit_reset: assert property (init_reset_o |-> limit_evt_o && state_r == LDS_ST_IDLE)
		else $error("initialization reset without limit event");
	a_l3_from_tref3: assert property ($rose(link_l3_o) |-> state_r == LDS_ST_DONE
		&& $past(state_r) == LDS_ST_TREF3)
		else $error("link state L3 entered outside third reference end");

	c_ack_path: cover property (state_r == LDS_ST_ACK ##1 state_r == LDS_ST_TREF2);
	c_nack_path: cover property (state_r == LDS_ST_NACK);
	c_resend: cover property (tx_rewind_o);
	c_done: cover property ($rose(link_l3_o));

endmodule

// >>> verif/lds_remote_model.sv
/*
 * lds_remote_model: far-end transceiver as seen through the local demodulator.
 * Assumes the bench calls send_msg and raises ack_req_i, and that sym_stb_i paces the line.
 */
`timescale 1ns/1ps
module lds_remote_model
	import lds_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic sym_stb_i,
	// line view and plan
	input wire lds_sym_type tx_sym_i,
	input wire logic more_i,
	input wire logic ack_req_i,
	// demodulator reports
	output lds_rx_type rx_o,
	output logic quiet_o,
	output logic ack_ok_o
);
	logic ack_seen_r;
	logic req_d_r;

	initial begin
		rx_o = '0;
	end

	// reverb only shows up inside a bit-modulated acknowledgement or message
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || rx_o.msg_end) begin
			ack_seen_r <= 1'b0;
		end else if (tx_sym_i == LDS_SYM_REVERB) begin
			ack_seen_r <= 1'b1;
		end
		req_d_r <= ack_req_i;
		ack_ok_o <= ack_req_i & ~req_d_r & ~reset_i;
	end

	assign quiet_o = ack_seen_r & ~more_i;

	task automatic send_msg(input logic [7:0] seq, input logic [8:0] oct, input logic ok);
		int n;
		n = 0;
		while (n < LDS_SEGUE_SYMS) begin
			@(negedge sys_clk_i);
			if (sym_stb_i) n++;
		end
		rx_o = {1'b1, ok, seq, oct};
		@(negedge sys_clk_i);
		// fields are stale once the end pulse is gone
		rx_o = {1'b0, ~ok, ~seq, ~oct};
	endtask
endmodule

// >>> verif/tb_lds_seq.sv
/*
 * tb_lds_seq: self-checking bench of the exchange-phase sequencer.
 * Assumes lds_remote_model on the far side; strobes every second clock.
 */
`timescale 1ns/1ps
module tb_lds_seq;
	import lds_pkg::*;
	logic sys_clk_i, reset_i, clk_en_i, sym_stb_i, exch_start_i;
	logic [3:0] resend_limit_i;
	lds_rx_type rx_i;
	logic rx_quiet_i, rx_ack_ok_i, tx_bit_i, tx_last_i, tx_more_i;
	logic tx_take_o, tx_next_o, tx_rewind_o, rec_valid_o, rec_ready_i;
	lds_sym_type tx_sym_o;
	lds_rec_type rec_o;
	logic init_reset_o, limit_evt_o, link_l3_o, r_more, ack_req, take_r;
	logic [1:0] idx;
	int errors, n_checks, n_rew, n_next, n_init, n_take, ack_at, r0;
	// local message bits 0,1,1,0
	localparam logic [3:0] PAT = 4'h6;

	lds_seq #(.RESEND_W(4)) u_lds_seq (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.clk_en_i(clk_en_i), .sym_stb_i(sym_stb_i), .exch_start_i(exch_start_i),
		.resend_limit_i(resend_limit_i), .rx_i(rx_i), .rx_quiet_i(rx_quiet_i),
		.rx_ack_ok_i(rx_ack_ok_i), .tx_bit_i(tx_bit_i), .tx_last_i(tx_last_i),
		.tx_more_i(tx_more_i), .tx_take_o(tx_take_o), .tx_next_o(tx_next_o),
		.tx_rewind_o(tx_rewind_o), .tx_sym_o(tx_sym_o), .rec_valid_o(rec_valid_o),
		.rec_ready_i(rec_ready_i), .rec_o(rec_o), .init_reset_o(init_reset_o),
		.limit_evt_o(limit_evt_o), .link_l3_o(link_l3_o));

	lds_remote_model u_lds_remote_model (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.sym_stb_i(sym_stb_i), .tx_sym_i(tx_sym_o), .more_i(r_more), .ack_req_i(ack_req),
		.rx_o(rx_i), .quiet_o(rx_quiet_i), .ack_ok_o(rx_ack_ok_i));

	assign tx_bit_i = PAT[idx];
	assign tx_last_i = (idx == 2'h3);

	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i) begin
		take_r <= tx_take_o;
		n_rew <= n_rew + int'(tx_rewind_o);
		n_next <= n_next + int'(tx_next_o);
		n_init <= n_init + int'(init_reset_o);
		n_take <= n_take + int'(tx_take_o);
	end

	always @(negedge sys_clk_i) begin
		sym_stb_i <= ~sym_stb_i & ~reset_i;
		if (reset_i || tx_rewind_o || tx_next_o) idx <= 2'h0;
		else if (take_r) idx <= idx + 2'h1;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// returns at the negedge just after a strobe edge
	task automatic next_sym();
		@(negedge sys_clk_i);
		while (!sym_stb_i) @(negedge sys_clk_i);
	endtask

	// strobes during which the line shows s; may raise the acknowledgement at ack_at
	task automatic run_len(input lds_sym_type s, input int n);
		int k, w;
		k = 0;
		w = 0;
		while (tx_sym_o !== s && w < 2000) begin
			next_sym();
			w++;
		end
		while (tx_sym_o === s && k < 2000) begin
			k++;
			ack_req = (k == ack_at);
			next_sym();
		end
		ack_req = 1'b0;
		check(32'(k), 32'(n));
	endtask

	task automatic no_segue(input int n);
		int k, bad;
		bad = 0;
		for (k = 0; k < n; k++) begin
			next_sym();
			if (tx_sym_o !== LDS_SYM_REF) bad++;
		end
		check(32'(bad), 32'h0);
	endtask

	task automatic exch(input logic [7:0] seq, input logic [8:0] oct, input logic ok,
		input logic ack);
		int i, k;
		u_lds_remote_model.send_msg(seq, oct, ok);
		if (ack) begin
			k = 0;
			while (tx_sym_o === LDS_SYM_REF && k < 200) begin
				next_sym();
				k++;
			end
			check(32'(k <= LDS_DECIDE_MAX_SYMS), 32'h1);
			for (i = 0; i < 4; i++) begin
				run_len(LDS_SYM_SEGUE, 8);
				run_len(LDS_SYM_REVERB, 8);
			end
		end
		// no acknowledgement pattern, and back in the first reference when not quiet
		if (!ack || r_more) no_segue(400);
	endtask

	task automatic start();
		@(negedge sys_clk_i);
		exch_start_i = 1'b1;
		@(negedge sys_clk_i);
		exch_start_i = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		check(32'(tx_sym_o), 32'(LDS_SYM_REF));
	endtask

	task automatic do_reset();
		reset_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		reset_i = 1'b0;
	endtask

	task automatic pop(input logic [7:0] seq, input logic [8:0] oct);
		check(32'(rec_valid_o), 32'h1);
		check(32'(rec_o.seq), 32'(seq));
		check(32'(rec_o.octets), 32'(oct));
		rec_ready_i = 1'b1;
		@(negedge sys_clk_i);
		rec_ready_i = 1'b0;
		@(negedge sys_clk_i);
	endtask

	// segue marker then the local bits, one bit per 8 strobes; each bit is taken once
	task automatic send_local();
		int t0;
		t0 = n_take;
		run_len(LDS_SYM_SEGUE, 64);
		run_len(LDS_SYM_REVERB, 8);
		run_len(LDS_SYM_SEGUE, 16);
		run_len(LDS_SYM_REVERB, 8);
		check(32'(n_take - t0), 32'h4);
	endtask

	task automatic buffer_and_nack();
		exch(8'h11, 9'h010, 1'b1, 1'b1);
		exch(8'h11, 9'h010, 1'b1, 1'b1);
		exch(8'h22, 9'h102, 1'b1, 1'b1);
		exch(8'h33, 9'h102, 1'b1, 1'b0);
		pop(8'h11, 9'h010);
		pop(8'h22, 9'h102);
		check(32'(rec_valid_o), 32'h0);
		exch(8'h33, 9'h010, 1'b1, 1'b0);
		exch(8'h33, 9'h102, 1'b0, 1'b0);
	endtask

	task automatic local_flow();
		r_more = 1'b0;
		exch(8'h33, 9'h102, 1'b1, 1'b1);
		run_len(LDS_SYM_REF, 256);
		send_local();
		r0 = n_rew;
		run_len(LDS_SYM_REF, 256);
		send_local();
		check(32'(n_rew - r0), 32'h1);
		ack_at = 20;
		run_len(LDS_SYM_REF, 256);
		check(32'(n_next), 32'h1);
		send_local();
		tx_more_i = 1'b0;
		run_len(LDS_SYM_REF, 256);
		ack_at = -1;
		repeat (2) @(negedge sys_clk_i);
		check(32'(link_l3_o), 32'h1);
		check(32'(tx_sym_o), 32'(LDS_SYM_QUIET));
	endtask

	task automatic limit_case();
		do_reset();
		check(32'(link_l3_o), 32'h0);
		resend_limit_i = 4'h2;
		start();
		exch(8'h11, 9'h010, 1'b1, 1'b1);
		run_len(LDS_SYM_REF, 256);
		send_local();
		r0 = n_init;
		run_len(LDS_SYM_REF, 256);
		send_local();
		run_len(LDS_SYM_REF, 256);
		repeat (2) @(negedge sys_clk_i);
		check(32'(n_init - r0), 32'h1);
		check(32'(limit_evt_o), 32'h1);
	endtask

	// clock enable low: a start request must not reach the frozen sequencer
	task automatic freeze_case();
		clk_en_i = 1'b0;
		exch_start_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		exch_start_i = 1'b0;
		clk_en_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		check(32'(limit_evt_o), 32'h1);
		check(32'(tx_sym_o), 32'(LDS_SYM_QUIET));
	endtask

	initial begin
		reset_i = 1'b1;
		clk_en_i = 1'b1;
		sym_stb_i = 1'b0;
		exch_start_i = 1'b0;
		resend_limit_i = 4'h3;
		tx_more_i = 1'b1;
		rec_ready_i = 1'b0;
		r_more = 1'b1;
		ack_req = 1'b0;
		ack_at = -1;
		idx = 2'h0;
		do_reset();
		check(32'(tx_sym_o), 32'(LDS_SYM_QUIET));
		check(32'(rec_valid_o), 32'h0);
		check(32'(link_l3_o), 32'h0);
		check(32'(limit_evt_o), 32'h0);
		start();
		buffer_and_nack();
		local_flow();
		limit_case();
		freeze_case();
		results();
	end

	// whole run needs roughly 11000 clocks
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		errors++;
		results();
	end
endmodule
